/* rtl/eeprom_pkg.sv */
package eeprom_pkg;

    // Command word layout
    localparam int          WORD_W         = 16;
    localparam int          WR_BIT         = 15;
    localparam int          ADDR_MSB       = 10;
    localparam int          ADDR_LSB       = 4;
    localparam logic [15:0] ENTRY_CODE     = 16'hABCD;
    localparam logic [15:0] NOP_CODE       = 16'hFFFF;

    // Line addresses
    localparam logic [6:0]  LINE_FIRST     = 7'h40;
    localparam logic [6:0]  LINE_LAST      = 7'h51;
    localparam int          LINE_COUNT     = 18;
    localparam logic [6:0]  CTRL_LINE      = 7'h3E;
    localparam logic [6:0]  MON_LINE       = 7'h25;
    localparam logic [6:0]  FAIL_LINE      = 7'h01;

    // Data words written to the control line
    localparam logic [15:0] OP_SET_ZEROS   = 16'h0248;
    localparam logic [15:0] OP_PROG_ZEROS  = 16'h024E;
    localparam logic [15:0] OP_PROG_ONES   = 16'h024F;
    localparam logic [15:0] OP_REFRESH     = 16'h024C;

    // Reset values of the control lines
    localparam logic [15:0] MON_RESET      = 16'h0000;
    localparam logic [15:0] FAIL_RESET     = 16'h0001;
    localparam int          MON_OFF_BIT    = 15;

    // Checksum
    localparam logic [7:0]  CRC_POLY       = 8'h1D;
    localparam logic [7:0]  CRC_SEED       = 8'hAA;
    localparam logic [7:0]  CRC_INVERT     = 8'hFF;
    localparam logic [4:0]  CRC_START_LINE = 5'h03;
    localparam int          CRC_LINE       = 2;
    localparam logic [5:0]  CRC_LAST_BYTE  = 6'h22;
    localparam logic [5:0]  CRC_CMP_SLOT   = 6'h23;

    // Timing
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          PROG_HOLD_MS    = 30;
    localparam int          REFRESH_WAIT_US = 100;
    // Scaled per unit first: the plain product of the wait overflows a 32-bit int
    localparam int          PROG_HOLD_CYC   = PROG_HOLD_MS * (CLK_HZ / 1000);
    localparam int          REFRESH_WAIT_CYC =
        REFRESH_WAIT_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_CMD    = 2'b01,
        ST_DATA   = 2'b10
    } link_state_e;

    typedef enum logic [1:0] {
        PEND_NONE  = 2'b00,
        PEND_ZEROS = 2'b01,
        PEND_ONES  = 2'b10
    } pend_op_e;

    // One byte folded MSB first; carry out of bit 7 applies the low polynomial byte
    function automatic logic [7:0] crc8_fold(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int b = 0; b < 8; b++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

endpackage

/* rtl/crc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface crc_link_if;
    logic       load;
    logic       step;
    logic [7:0] data;
    logic [7:0] crc;

    modport host (output load, output step, output data, input crc);
    modport unit (input load, input step, input data, output crc);
endinterface
`default_nettype wire

/* rtl/crc8_byte_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module crc8_byte_unit (
    // Clock and reset
    input wire logic    i_clk_sys,
    input wire logic    i_rst,
    // Byte stream
    crc_link_if.unit    lnk
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;

    always_comb begin
        nxt_crc = crc_ff;
        if (lnk.load) begin
            nxt_crc = eeprom_pkg::crc8_fold(eeprom_pkg::CRC_SEED, lnk.data);
        end else if (lnk.step) begin
            nxt_crc = eeprom_pkg::crc8_fold(crc_ff, lnk.data);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            crc_ff <= 8'h00;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign lnk.crc = crc_ff;

    // Seed AA folded with a zero byte gives 73 after eight shifts
    a_seed_fold_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        lnk.load && lnk.data == 8'h00 |=> crc_ff == 8'h73)
        else $error("seed fold of zero byte wrong");

    a_poly_single_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        lnk.step && !lnk.load && (crc_ff ^ lnk.data) == 8'h80 |=> crc_ff == 8'h26)
        else $error("polynomial step of 0x80 wrong");
endmodule
`default_nettype wire

/* rtl/eeprom_crc_program_sequencer.sv */
// Notes on behaviour
// - Checksum is CRC-8, polynomial x8+x4+x3+x2+1, MSB first, 0x1D on carry.
// - CRC register starts at seed AA before the first byte.
// - Bytes fold from line 43 hex onward, high byte before low byte.
// - After the last line wrap to line 40 through high byte of line 42.
// - Final checksum is the accumulated CRC inverted.
// - Span is 18 lines, minus the checksum byte itself.
// - Check passes only when low byte of line 2 equals computed checksum.
// - Device checks its image continuously; changes need a new checksum.
`timescale 1ns/1ns
`default_nettype none
module eeprom_crc_program_sequencer #(
    parameter int unsigned PROG_HOLD_CYCLES = eeprom_pkg::PROG_HOLD_CYC
) (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Command words from the interface framer
    input  wire logic        i_word_valid,
    input  wire logic [15:0] i_word,
    output logic             o_resp_valid,
    output logic [15:0]      o_resp_word,
    // Programming voltage detector on the second over-current pin
    input  wire logic        i_second_overcurrent_pin,
    // Status
    output logic             o_interface_active,
    output logic             o_sensing_monitor_off,
    output logic             o_fail_ind_en,
    output logic             o_refresh_busy,
    output logic             o_crc_ok,
    output logic             o_crc_done
);
    localparam int N = eeprom_pkg::LINE_COUNT;

    eeprom_pkg::link_state_e state_ff,    nxt_state;
    eeprom_pkg::pend_op_e    pend_ff,     nxt_pend;
    logic [6:0]              prev_addr_ff, nxt_prev_addr;
    logic [6:0]              wr_addr_ff,  nxt_wr_addr;
    logic                    resp_valid_ff, nxt_resp_valid;
    logic [15:0]             resp_word_ff, nxt_resp_word;
    logic [15:0]             mon_ff,      nxt_mon;
    logic [15:0]             fail_ff,     nxt_fail;
    logic [19:0]             hold_cnt_ff, nxt_hold_cnt;
    logic [11:0]             wait_cnt_ff, nxt_wait_cnt;
    logic [15:0]             mem_ff  [N];
    logic [15:0]             nxt_mem [N];
    logic [15:0]             wbuf_ff [N];
    logic [15:0]             nxt_wbuf[N];
    logic                    pin_meta_ff, pin_sync_ff;
    logic                    refresh_done;

    // Pin level crosses from outside: two flops before use
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= i_second_overcurrent_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    function automatic logic [15:0] line_value(input logic [6:0] a);
        logic [4:0] idx;
        idx = 5'(a - eeprom_pkg::LINE_FIRST);
        if (a >= eeprom_pkg::LINE_FIRST && a <= eeprom_pkg::LINE_LAST) begin
            return mem_ff[idx];
        end else if (a == eeprom_pkg::MON_LINE) begin
            return mon_ff;
        end else if (a == eeprom_pkg::FAIL_LINE) begin
            return fail_ff;
        end else begin
            return 16'h0000;
        end
    endfunction

    assign refresh_done = (wait_cnt_ff == 12'h001);

    always_comb begin
        logic [4:0] widx;
        widx           = 5'(wr_addr_ff - eeprom_pkg::LINE_FIRST);
        nxt_state      = state_ff;
        nxt_pend       = pend_ff;
        nxt_prev_addr  = prev_addr_ff;
        nxt_wr_addr    = wr_addr_ff;
        nxt_resp_valid = 1'b0;
        nxt_resp_word  = resp_word_ff;
        nxt_mon        = mon_ff;
        nxt_fail       = fail_ff;
        nxt_hold_cnt   = 20'h0_0000;
        nxt_wait_cnt   = (wait_cnt_ff != 12'h000) ? wait_cnt_ff - 12'h001 : 12'h000;
        nxt_mem        = mem_ff;
        nxt_wbuf       = wbuf_ff;
        case (state_ff)
            eeprom_pkg::ST_LOCKED: begin
                // Nothing is answered until the entry word arrives; only the entry word leaves this mode
                if (i_word_valid && i_word == eeprom_pkg::ENTRY_CODE) begin
                    nxt_state = eeprom_pkg::ST_CMD;
                end
            end
            eeprom_pkg::ST_CMD: begin
                if (i_word_valid) begin
                    nxt_resp_valid = 1'b1;
                    nxt_resp_word  = line_value(prev_addr_ff);
                    if (i_word != eeprom_pkg::NOP_CODE) begin
                        nxt_prev_addr = i_word[eeprom_pkg::ADDR_MSB:eeprom_pkg::ADDR_LSB];
                        if (i_word[eeprom_pkg::WR_BIT]) begin
                            nxt_wr_addr = i_word[eeprom_pkg::ADDR_MSB:eeprom_pkg::ADDR_LSB];
                            nxt_state   = eeprom_pkg::ST_DATA;
                        end
                    end
                end
            end
            eeprom_pkg::ST_DATA: begin
                if (i_word_valid) begin
                    nxt_state = eeprom_pkg::ST_CMD;
                    if (wr_addr_ff == eeprom_pkg::MON_LINE) begin
                        nxt_mon = i_word;
                    end else if (wr_addr_ff == eeprom_pkg::FAIL_LINE) begin
                        nxt_fail = i_word;
                    end else if (wr_addr_ff == eeprom_pkg::CTRL_LINE) begin
                        if (i_word == eeprom_pkg::OP_SET_ZEROS) begin
                            // Buffer starts from the live image so unwritten lines survive
                            nxt_wbuf = mem_ff;
                        end else if (i_word == eeprom_pkg::OP_PROG_ZEROS) begin
                            nxt_pend = eeprom_pkg::PEND_ZEROS;
                        end else if (i_word == eeprom_pkg::OP_PROG_ONES) begin
                            nxt_pend = eeprom_pkg::PEND_ONES;
                        end else if (i_word == eeprom_pkg::OP_REFRESH) begin
                            nxt_wait_cnt = 12'(eeprom_pkg::REFRESH_WAIT_CYC);
                        end
                    end else if (wr_addr_ff >= eeprom_pkg::LINE_FIRST &&
                                 wr_addr_ff <= eeprom_pkg::LINE_LAST) begin
                        nxt_wbuf[widx] = i_word;
                    end
                end
            end
            default: begin
                nxt_state = eeprom_pkg::ST_LOCKED;
            end
        endcase
        // Operation lands only after the voltage has stood for the whole hold time
        if (pin_sync_ff && pend_ff != eeprom_pkg::PEND_NONE) begin
            if (hold_cnt_ff >= 20'(PROG_HOLD_CYCLES - 1)) begin
                for (int i = 0; i < N; i++) begin
                    nxt_mem[i] = (pend_ff == eeprom_pkg::PEND_ZEROS) ? 16'h0000
                                                                    : mem_ff[i] | wbuf_ff[i];
                end
                nxt_pend = (nxt_pend == pend_ff) ? eeprom_pkg::PEND_NONE : nxt_pend;
            end else begin
                nxt_hold_cnt = hold_cnt_ff + 20'h0_0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff      <= eeprom_pkg::ST_LOCKED;
            pend_ff       <= eeprom_pkg::PEND_NONE;
            prev_addr_ff  <= 7'h00;
            wr_addr_ff    <= 7'h00;
            resp_valid_ff <= 1'b0;
            resp_word_ff  <= 16'h0000;
            mon_ff        <= eeprom_pkg::MON_RESET;
            fail_ff       <= eeprom_pkg::FAIL_RESET;
            hold_cnt_ff   <= 20'h0_0000;
            wait_cnt_ff   <= 12'h000;
            for (int i = 0; i < N; i++) begin
                mem_ff[i]  <= 16'h0000;
                wbuf_ff[i] <= 16'h0000;
            end
        end else begin
            state_ff      <= nxt_state;
            pend_ff       <= nxt_pend;
            prev_addr_ff  <= nxt_prev_addr;
            wr_addr_ff    <= nxt_wr_addr;
            resp_valid_ff <= nxt_resp_valid;
            resp_word_ff  <= nxt_resp_word;
            mon_ff        <= nxt_mon;
            fail_ff       <= nxt_fail;
            hold_cnt_ff   <= nxt_hold_cnt;
            wait_cnt_ff   <= nxt_wait_cnt;
            mem_ff        <= nxt_mem;
            wbuf_ff       <= nxt_wbuf;
        end
    end

    // Continuous checksum walk over the image
    crc_link_if crc_lnk ();
    crc8_byte_unit u_crc (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .lnk       (crc_lnk)
    );

    logic [5:0] crc_cnt_ff, nxt_crc_cnt;
    logic       crc_ok_ff,  nxt_crc_ok;
    logic       crc_done_ff, nxt_crc_done;
    logic [4:0] crc_line, crc_line_raw;
    assign crc_line_raw = 5'(crc_cnt_ff[5:1]) + eeprom_pkg::CRC_START_LINE;
    assign crc_line     = (crc_line_raw >= 5'(N)) ? crc_line_raw - 5'(N) : crc_line_raw;
    assign crc_lnk.load = (crc_cnt_ff == 6'h00);
    assign crc_lnk.step = (crc_cnt_ff != 6'h00) && (crc_cnt_ff <= eeprom_pkg::CRC_LAST_BYTE);
    assign crc_lnk.data = crc_cnt_ff[0] ? mem_ff[crc_line][7:0] : mem_ff[crc_line][15:8];

    always_comb begin
        nxt_crc_cnt  = crc_cnt_ff + 6'h01;
        nxt_crc_ok   = crc_ok_ff;
        nxt_crc_done = 1'b0;
        if (crc_cnt_ff == eeprom_pkg::CRC_CMP_SLOT) begin
            nxt_crc_cnt  = 6'h00;
            nxt_crc_done = 1'b1;
            nxt_crc_ok   = ((crc_lnk.crc ^ eeprom_pkg::CRC_INVERT) ==
                            mem_ff[eeprom_pkg::CRC_LINE][7:0]);
        end else if (refresh_done && crc_cnt_ff != 6'h00) begin
            // Fresh pass after refresh so the new image is judged promptly
            nxt_crc_cnt = 6'h00;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            crc_cnt_ff  <= 6'h00;
            crc_ok_ff   <= 1'b0;
            crc_done_ff <= 1'b0;
        end else begin
            crc_cnt_ff  <= nxt_crc_cnt;
            crc_ok_ff   <= nxt_crc_ok;
            crc_done_ff <= nxt_crc_done;
        end
    end

    assign o_resp_valid          = resp_valid_ff;
    assign o_resp_word           = resp_word_ff;
    assign o_interface_active    = (state_ff != eeprom_pkg::ST_LOCKED);
    assign o_sensing_monitor_off = mon_ff[eeprom_pkg::MON_OFF_BIT];
    assign o_fail_ind_en         = (fail_ff != 16'h0000);
    assign o_refresh_busy        = (wait_cnt_ff != 12'h000);
    assign o_crc_ok              = crc_ok_ff;
    assign o_crc_done            = crc_done_ff;

    sequence s_first_byte;
        crc_cnt_ff == 6'h00;
    endsequence
    sequence s_wrap_byte;
        crc_cnt_ff == 6'h1E && (wait_cnt_ff == 12'h000 || wait_cnt_ff > 12'h004);
    endsequence

    a_start_line_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_first_byte |-> crc_lnk.data == mem_ff[3][15:8] ##1 crc_lnk.data == mem_ff[3][7:0])
        else $error("walk does not start at line three high byte");

    a_wrap_to_base: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_wrap_byte |-> crc_lnk.data == mem_ff[0][15:8] ##4 crc_lnk.data == mem_ff[2][15:8])
        else $error("walk does not wrap to line zero");

    a_check_invert: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        crc_cnt_ff == eeprom_pkg::CRC_CMP_SLOT |=>
        o_crc_ok == (($past(crc_lnk.crc) ^ 8'hFF) == $past(mem_ff[2][7:0])))
        else $error("checksum compare wrong");

    a_span_period: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_crc_done && (wait_cnt_ff == 12'h000 || wait_cnt_ff > 12'h024) |-> ##36 o_crc_done)
        else $error("pass length is not 35 bytes plus compare");

    a_ok_tracks_done: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_crc_done |-> o_crc_ok == $past(o_crc_ok))
        else $error("check result moved outside compare");

    a_read_previous: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == eeprom_pkg::ST_CMD && i_word_valid |=>
        o_resp_valid && o_resp_word == $past(line_value(prev_addr_ff)))
        else $error("read answer is not previous line");

    a_entry_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_ff == eeprom_pkg::ST_LOCKED && !(i_word_valid && i_word == 16'hABCD) |=>
        !o_resp_valid && !o_interface_active)
        else $error("answered before entry word");

    a_hold_before_prog: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pend_ff != eeprom_pkg::PEND_NONE && !pin_sync_ff |=> pend_ff == $past(pend_ff))
        else $error("program operation without voltage");
endmodule
`default_nettype wire

/* dv/prog_model.sv */
`timescale 1ns/1ns
`default_nettype none
module prog_model (
    // Clock
    input  wire logic        i_clk_sys,
    // Word port toward the device
    output logic             o_word_valid,
    output logic [15:0]      o_word,
    // Programming voltage
    output logic             o_second_overcurrent_pin
);
    // Scaled hold: the device is built with a 20-cycle hold for simulation
    localparam int unsigned HOLD_CYC = 30;
    localparam int unsigned WAIT_CYC = 2500;

    initial begin
        o_word_valid             = 1'b0;
        o_word                   = 16'h0000;
        o_second_overcurrent_pin = 1'b0;
    end

    // Released word lines show the inverse so a stale value never reads as valid
    task automatic send(input logic [15:0] w);
        @(negedge i_clk_sys);
        o_word_valid = 1'b1;
        o_word       = w;
        @(negedge i_clk_sys);
        o_word_valid = 1'b0;
        o_word       = ~w;
    endtask

    task automatic enter();
        send(16'hABCD);
    endtask

    task automatic monitor_off();
        send(16'h8250);
        send(16'h8000);
    endtask

    task automatic fail_off();
        send(16'h8010);
        send(16'h0000);
    endtask

    task automatic ctrl_op(input logic [15:0] op);
        send(16'h83E0);
        send(op);
    endtask

    task automatic prog_voltage();
        @(negedge i_clk_sys);
        o_second_overcurrent_pin = 1'b1;
        repeat (HOLD_CYC) @(negedge i_clk_sys);
        o_second_overcurrent_pin = 1'b0;
    endtask

    // Writes the whole image; with do_zeros low only ones are added
    task automatic reprogram(input logic [15:0] img [18], input logic do_zeros);
        ctrl_op(16'h0248);
        if (do_zeros) begin
            ctrl_op(16'h024E);
            prog_voltage();
        end
        for (int i = 0; i < 18; i++) begin
            send({1'b1, 4'h0, 7'(7'h40 + 7'(i)), 4'h0});
            send(img[i]);
        end
        ctrl_op(16'h024F);
        prog_voltage();
    endtask

    task automatic refresh();
        ctrl_op(16'h024C);
        repeat (WAIT_CYC) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk_sys;
    logic        rst;
    logic        word_valid;
    logic [15:0] word;
    logic        pin;
    logic        resp_valid;
    logic [15:0] resp_word;
    logic        if_active;
    logic        mon_off;
    logic        fail_en;
    logic        refresh_busy;
    logic        crc_ok;
    logic        crc_done;
    int          error_cnt;
    int          comparisons;
    logic [15:0] img [18];
    logic [15:0] got;
    logic        seen;
    int          cnt;

    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    initial rst = 1'b1;

    prog_model pm (
        .i_clk_sys                (clk_sys),
        .o_word_valid             (word_valid),
        .o_word                   (word),
        .o_second_overcurrent_pin (pin)
    );

    eeprom_crc_program_sequencer #(.PROG_HOLD_CYCLES(20)) dut (
        .i_clk_sys                (clk_sys),
        .i_rst                    (rst),
        .i_word_valid             (word_valid),
        .i_word                   (word),
        .o_resp_valid             (resp_valid),
        .o_resp_word              (resp_word),
        .i_second_overcurrent_pin (pin),
        .o_interface_active       (if_active),
        .o_sensing_monitor_off    (mon_off),
        .o_fail_ind_en            (fail_en),
        .o_refresh_busy           (refresh_busy),
        .o_crc_ok                 (crc_ok),
        .o_crc_done               (crc_done)
    );

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic results();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        results();
    endtask

    // The answer pulse lasts one cycle, so every falling edge is looked at
    task automatic cmd(input logic [15:0] w);
        pm.send(w);
        seen = 1'b0;
        for (int k = 0; k < 3 && !seen; k++) begin
            if (resp_valid === 1'b1) begin
                seen = 1'b1;
                got  = resp_word;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask

    task automatic rd(input logic [15:0] w, input logic [15:0] e);
        cmd(w);
        check({15'h0000, seen}, 16'h0001);
        check(got, e);
    endtask

    task automatic wait_done();
        for (int n = 0; n < 2; n++) begin
            cnt = 0;
            while (crc_done !== 1'b1) begin
                @(negedge clk_sys);
                cnt++;
                if (cnt > 200) timed_out();
            end
            @(negedge clk_sys);
        end
    endtask

    function automatic logic [7:0] crc_ref(input logic [15:0] m [18]);
        logic [7:0] c;
        logic [15:0] l;
        c = 8'hAA;
        for (int k = 0; k < 35; k++) begin
            l = m[(k / 2 + 3) % 18];
            c = c ^ (k[0] ? l[7:0] : l[15:8]);
            for (int j = 0; j < 8; j++) begin
                c = c[7] ? ({c[6:0], 1'b0} ^ 8'h1D) : {c[6:0], 1'b0};
            end
        end
        return ~c;
    endfunction

    task automatic t_locked();
        @(negedge clk_sys);
        check({10'h000, if_active, mon_off, fail_en, refresh_busy, crc_ok, resp_valid},
              16'h0008);
        cmd(16'h0400);
        check({15'h0000, seen}, 16'h0000);
        check({15'h0000, if_active}, 16'h0000);
        pm.enter();
        @(negedge clk_sys);
        check({15'h0000, if_active}, 16'h0001);
    endtask

    task automatic t_controls();
        pm.monitor_off();
        @(negedge clk_sys);
        check({15'h0000, mon_off}, 16'h0001);
        pm.fail_off();
        @(negedge clk_sys);
        check({15'h0000, fail_en}, 16'h0000);
        rd(16'h0250, 16'h0000);
        rd(16'hFFFF, 16'h8000);
    endtask

    task automatic t_readback(input logic [15:0] e [18]);
        cmd(16'h0400);
        for (int i = 1; i < 18; i++) begin
            rd({5'h00, 7'(7'h40 + 7'(i)), 4'h0}, e[i - 1]);
        end
        rd(16'hFFFF, e[17]);
    endtask

    task automatic t_program();
        for (int i = 0; i < 18; i++) begin
            img[i] = 16'(i * 16'h0A52 + 16'h3C10);
        end
        img[2][7:0] = crc_ref(img);
        pm.reprogram(img, 1'b1);
        t_readback(img);
        wait_done();
        check({15'h0000, crc_ok}, 16'h0001);
    endtask

    // Adding one bit without a new checksum must be caught by the running check
    task automatic t_corrupt();
        img[5] = img[5] | 16'h0001;
        pm.reprogram(img, 1'b0);
        t_readback(img);
        wait_done();
        check({15'h0000, crc_ok}, 16'h0000);
    endtask

    task automatic t_refresh();
        cnt = 0;
        fork
            pm.refresh();
            begin
                while (refresh_busy !== 1'b1 && cnt < 10) begin
                    @(negedge clk_sys);
                    cnt++;
                end
                check({15'h0000, refresh_busy}, 16'h0001);
                cnt = 0;
                while (refresh_busy === 1'b1) begin
                    @(negedge clk_sys);
                    cnt++;
                    if (cnt > 3000) timed_out();
                end
                check(16'((cnt >= 2499 && cnt <= 2501) ? 1 : 0), 16'h0001);
            end
        join
        wait_done();
        check({15'h0000, crc_ok}, 16'h0000);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        timed_out();
    end

    initial begin
        error_cnt   = 0;
        comparisons = 0;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        t_locked();
        t_controls();
        t_readback(img);
        t_program();
        t_corrupt();
        t_refresh();
        results();
    end

    initial begin
        for (int i = 0; i < 18; i++) begin
            img[i] = 16'h0000;
        end
    end
endmodule
`default_nettype wire
